// ---- design/ccr_regs.sv ----
// Charger configuration registers 04h-07h with field decoding
module ccr_regs #(
    parameter longint SEC_CYCLES = ccr_pkg::SECOND_CYCLES
) (
    input wire logic clock,                 // Device clock, 40 MHz
    input wire logic rst,                   // Async reset, high
    input wire logic [7:0] reg_addr,        // Register address
    input wire logic reg_wr,                // Write strobe
    input wire logic [7:0] reg_wdata,       // Write data
    output logic [7:0] reg_rdata,           // Read data, one cycle late
    input wire logic reg_reset_req,         // Software register reset
    input wire logic watchdog_restart_wr,   // Host wrote restart bit
    output logic watchdog_restart,          // Restart bit as read back
    output logic watchdog_expired,          // Expiry pulse
    input wire logic pulse_up_wr,           // Host wrote pulse-up bit
    input wire logic pulse_down_wr,         // Host wrote pulse-down bit
    input wire logic pulse_done,            // Pulse sequence finished
    output logic pulse_ctrl_enable,         // Pulse control enabled
    output logic pulse_volt_up_req,         // Pulse-up request
    output logic pulse_volt_down_req,       // Pulse-down request
    output logic [11:0] fast_charge_current,   // Fast current, mA
    output logic fast_charge_off,              // Charging disabled
    output logic [10:0] precharge_current,     // Precharge, mA
    output logic [10:0] termination_current,   // Termination, mA
    output logic [12:0] charge_voltage,        // Charge voltage, mV
    output logic [11:0] precharge_exit_threshold, // Exit level, mV
    output logic recharge_threshold,           // Recharge select bit
    output logic termination_enable,           // Termination enabled
    output logic status_pin_disable,           // Status pin off
    output logic [7:0] watchdog_period,        // Period, s, 0 = off
    output logic safety_timer_enable,          // Safety timer on
    output logic [4:0] safety_timer_duration,  // Duration, hours
    output logic [11:0] cool_band_current      // Cool band current, mA
);
    // Stored register contents
    logic [7:0] fast_curr_reg;
    logic [7:0] pre_term_reg;
    logic [7:0] volt_reg;
    logic [7:0] timer_reg;

    // Restart bit and pulse requests as held state
    logic restart_bit;
    logic up_req;
    logic down_req;

    // Watchdog expiry from the timer
    logic wd_expire;

    // Any event that puts every field back to its default
    wire restore = reg_reset_req || wd_expire;

    // Address decode for writes
    wire wr_fast = reg_wr && (reg_addr == ccr_pkg::OFS_FAST_CURR);
    wire wr_pre = reg_wr && (reg_addr == ccr_pkg::OFS_PRE_TERM);
    wire wr_volt = reg_wr && (reg_addr == ccr_pkg::OFS_VOLT);
    wire wr_timer = reg_wr && (reg_addr == ccr_pkg::OFS_TIMER);

    // Read selection; addresses outside the bank read as zero
    wire [7:0] rd_sel =
        (reg_addr == ccr_pkg::OFS_FAST_CURR) ? fast_curr_reg :
        (reg_addr == ccr_pkg::OFS_PRE_TERM) ? pre_term_reg :
        (reg_addr == ccr_pkg::OFS_VOLT) ? volt_reg :
        (reg_addr == ccr_pkg::OFS_TIMER) ? timer_reg : 8'h00;

    // Next register values; restore beats a write in the same cycle
    wire [7:0] next_fast_curr = restore ? ccr_pkg::RST_FAST_CURR :
        wr_fast ? reg_wdata : fast_curr_reg;
    wire [7:0] next_pre_term = restore ? ccr_pkg::RST_PRE_TERM :
        wr_pre ? reg_wdata : pre_term_reg;
    wire [7:0] next_volt = restore ? ccr_pkg::RST_VOLT :
        wr_volt ? reg_wdata : volt_reg;
    wire [7:0] next_timer = restore ? ccr_pkg::RST_TIMER :
        wr_timer ? reg_wdata : timer_reg;

    // Register storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fast_curr_reg <= ccr_pkg::RST_FAST_CURR;
            pre_term_reg <= ccr_pkg::RST_PRE_TERM;
            volt_reg <= ccr_pkg::RST_VOLT;
            timer_reg <= ccr_pkg::RST_TIMER;
        end else begin
            fast_curr_reg <= next_fast_curr;
            pre_term_reg <= next_pre_term;
            volt_reg <= next_volt;
            timer_reg <= next_timer;
        end
    end

    // Field extraction from the stored registers
    wire pulse_en = fast_curr_reg[ccr_pkg::FC_PULSE_EN_BIT];
    wire [6:0] fc_code = fast_curr_reg[ccr_pkg::FC_CODE_MSB:0];
    wire [5:0] fc_low = fast_curr_reg[ccr_pkg::FC_LOW_MSB:0];
    wire [3:0] pre_code =
        pre_term_reg[ccr_pkg::PT_PRE_MSB:ccr_pkg::PT_PRE_LSB];
    wire [3:0] term_code = pre_term_reg[ccr_pkg::PT_TERM_MSB:0];
    wire [5:0] cv_code =
        volt_reg[ccr_pkg::CV_CODE_MSB:ccr_pkg::CV_CODE_LSB];
    wire [1:0] wd_sel = timer_reg[ccr_pkg::TC_WD_MSB:ccr_pkg::TC_WD_LSB];
    wire [1:0] tmr_sel =
        timer_reg[ccr_pkg::TC_TMR_MSB:ccr_pkg::TC_TMR_LSB];

    // Fast-charge current: clamp first, then 64mA per step
    wire [6:0] fc_clamped = (fc_code > ccr_pkg::FC_CODE_MAX) ?
        ccr_pkg::FC_CODE_MAX : fc_code;
    wire [11:0] fc_ma = {fc_clamped[5:0], 6'h00};
    wire fc_zero = (fc_code == 7'h00);

    // Precharge and termination: code plus one, times 64mA; precharge is zero when fc_low is zero
    wire [4:0] pre_steps = {1'b0, pre_code} + 5'h01;
    wire [4:0] term_steps = {1'b0, term_code} + 5'h01;
    wire [10:0] pre_ma = (fc_low == 6'h00) ? 11'h000 :
        {pre_steps, 6'h00};
    wire [10:0] term_ma = {term_steps, 6'h00};

    // Charge voltage: clamp, then offset plus 16mV per step
    wire [5:0] cv_clamped = (cv_code > ccr_pkg::CV_CODE_MAX) ?
        ccr_pkg::CV_CODE_MAX : cv_code;
    wire [12:0] cv_mv = ccr_pkg::CV_OFFSET_MV +
        {3'h0, cv_clamped, 4'h0};

    // Precharge exit threshold select
    wire [11:0] exit_mv = volt_reg[ccr_pkg::CV_EXIT_BIT] ?
        ccr_pkg::EXIT_HIGH_MV : ccr_pkg::EXIT_LOW_MV;

    // Watchdog period decode
    logic [7:0] wd_s;
    always_comb begin
        case (wd_sel)
            2'b01: wd_s = ccr_pkg::WD_40S;
            2'b10: wd_s = ccr_pkg::WD_80S;
            2'b11: wd_s = ccr_pkg::WD_160S;
            default: wd_s = 8'h00;
        endcase
    end

    // Safety timer duration decode
    logic [4:0] tmr_h;
    always_comb begin
        case (tmr_sel)
            2'b00: tmr_h = ccr_pkg::TMR_5H;
            2'b01: tmr_h = ccr_pkg::TMR_8H;
            2'b10: tmr_h = ccr_pkg::TMR_12H;
            default: tmr_h = ccr_pkg::TMR_20H;
        endcase
    end

    // Cool band scaling; divide by five rounds down to whole mA
    wire [11:0] cool_fifth = 12'(fc_ma / 12'h005);
    wire [11:0] cool_half = {1'b0, fc_ma[11:1]};
    wire [11:0] cool_ma = timer_reg[ccr_pkg::TC_COOL_BIT] ?
        cool_fifth : cool_half;

    // Fast-charge current in mA, already clamped
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            fast_charge_current <= 12'h000;
        else
            fast_charge_current <= fc_ma;
    end

    // Charge-off flag; a zero code must not regulate to 0mA
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            fast_charge_off <= 1'b0;
        else
            fast_charge_off <= fc_zero;
    end

    // Precharge current, forced to zero when the low six fast-code bits are zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            precharge_current <= 11'h000;
        else
            precharge_current <= pre_ma;
    end

    // Termination current in mA
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            termination_current <= 11'h000;
        else
            termination_current <= term_ma;
    end

    // Charge voltage in mV, already clamped
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            charge_voltage <= 13'h0000;
        else
            charge_voltage <= cv_mv;
    end

    // Precharge exit threshold in mV
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            precharge_exit_threshold <= 12'h000;
        else
            precharge_exit_threshold <= exit_mv;
    end

    // Recharge select bit, passed through as stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            recharge_threshold <= 1'b0;
        else
            recharge_threshold <= volt_reg[ccr_pkg::CV_RECHG_BIT];
    end

    // Termination enable bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            termination_enable <= 1'b0;
        else
            termination_enable <= timer_reg[ccr_pkg::TC_TERM_EN_BIT];
    end

    // Status pin disable bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            status_pin_disable <= 1'b0;
        else
            status_pin_disable <=
                timer_reg[ccr_pkg::TC_STATUS_OFF_BIT];
    end

    // Watchdog period in seconds; zero means off
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            watchdog_period <= 8'h00;
        else
            watchdog_period <= wd_s;
    end

    // Safety timer enable bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            safety_timer_enable <= 1'b0;
        else
            safety_timer_enable <=
                timer_reg[ccr_pkg::TC_TMR_EN_BIT];
    end

    // Safety timer duration in hours
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            safety_timer_duration <= 5'h00;
        else
            safety_timer_duration <= tmr_h;
    end

    // Cool band current; the slow divide settles before this flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            cool_band_current <= 12'h000;
        else
            cool_band_current <= cool_ma;
    end

    // Read data follows the address one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rd_sel;
    end

    // Restart bit: a new write wins over the self-clear
    wire next_restart_bit = watchdog_restart_wr ? 1'b1 : 1'b0;

    // Host watchdog; the held bit itself restarts the count
    ccr_watchdog #(
        .SEC_CYCLES(int'(SEC_CYCLES))
    ) u_watchdog (
        .clock(clock),
        .rst(rst),
        .restart(restart_bit),
        .period_s(wd_s),
        .expire(wd_expire)
    );

    // Pulse requests: set only while enabled, set wins over completion.
    // Dropping the enable cancels a pending request so it has no effect.
    wire next_up_req = restore ? 1'b0 :
        !pulse_en ? 1'b0 :
        pulse_up_wr ? 1'b1 :
        pulse_done ? 1'b0 : up_req;
    wire next_down_req = restore ? 1'b0 :
        !pulse_en ? 1'b0 :
        pulse_down_wr ? 1'b1 :
        pulse_done ? 1'b0 : down_req;

    // Request and restart flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            restart_bit <= 1'b0;
            up_req <= 1'b0;
            down_req <= 1'b0;
        end else begin
            restart_bit <= next_restart_bit;
            up_req <= next_up_req;
            down_req <= next_down_req;
        end
    end

    // Outputs mirror the held flags
    assign watchdog_restart = restart_bit;
    assign pulse_volt_up_req = up_req;
    assign pulse_volt_down_req = down_req;

    // Enable output, one cycle behind the stored bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            pulse_ctrl_enable <= 1'b0;
        else
            pulse_ctrl_enable <= pulse_en;
    end

    // Expiry output, one cycle after the restore it caused
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            watchdog_expired <= 1'b0;
        else
            watchdog_expired <= wd_expire;
    end
endmodule

// ---- design/ccr_pkg.sv ----
// Constants shared by the charger configuration register bank
package ccr_pkg;
    // Register offsets
    localparam logic [7:0] OFS_FAST_CURR = 8'h04;
    localparam logic [7:0] OFS_PRE_TERM = 8'h05;
    localparam logic [7:0] OFS_VOLT = 8'h06;
    localparam logic [7:0] OFS_TIMER = 8'h07;
    // Reset values
    localparam logic [7:0] RST_FAST_CURR = 8'h20;
    localparam logic [7:0] RST_PRE_TERM = 8'h13;
    localparam logic [7:0] RST_VOLT = 8'h5E;
    localparam logic [7:0] RST_TIMER = 8'h9D;
    // Field positions, fast-charge current register
    localparam int FC_PULSE_EN_BIT = 7;
    localparam int FC_CODE_MSB = 6;
    localparam int FC_LOW_MSB = 5;
    // Field positions, precharge and termination register
    localparam int PT_PRE_MSB = 7;
    localparam int PT_PRE_LSB = 4;
    localparam int PT_TERM_MSB = 3;
    // Field positions, charge voltage register
    localparam int CV_CODE_MSB = 7;
    localparam int CV_CODE_LSB = 2;
    localparam int CV_EXIT_BIT = 1;
    localparam int CV_RECHG_BIT = 0;
    // Field positions, timer control register
    localparam int TC_TERM_EN_BIT = 7;
    localparam int TC_STATUS_OFF_BIT = 6;
    localparam int TC_WD_MSB = 5;
    localparam int TC_WD_LSB = 4;
    localparam int TC_TMR_EN_BIT = 3;
    localparam int TC_TMR_MSB = 2;
    localparam int TC_TMR_LSB = 1;
    localparam int TC_COOL_BIT = 0;
    // Decoding constants
    localparam logic [6:0] FC_CODE_MAX = 7'h3F;
    localparam logic [5:0] CV_CODE_MAX = 6'h30;
    localparam logic [12:0] CV_OFFSET_MV = 13'h0F00;
    localparam logic [11:0] EXIT_LOW_MV = 12'hAF0;
    localparam logic [11:0] EXIT_HIGH_MV = 12'hBB8;
    // Watchdog periods in seconds
    localparam logic [7:0] WD_40S = 8'h28;
    localparam logic [7:0] WD_80S = 8'h50;
    localparam logic [7:0] WD_160S = 8'hA0;
    // Safety timer durations in hours
    localparam logic [4:0] TMR_5H = 5'h05;
    localparam logic [4:0] TMR_8H = 5'h08;
    localparam logic [4:0] TMR_12H = 5'h0C;
    localparam logic [4:0] TMR_20H = 5'h14;
    // Clock rate and one second in cycles
    localparam longint CLOCK_HZ = 40000000;
    localparam longint SECOND_S = 1;
    localparam longint SECOND_CYCLES = CLOCK_HZ * SECOND_S;
endpackage

// ---- design/ccr_watchdog.sv ----
// Host watchdog timer counting whole seconds up to the chosen period
module ccr_watchdog #(
    parameter int SEC_CYCLES = 40000000
) (
    input wire logic clock,            // Device clock
    input wire logic rst,              // Async reset, high
    input wire logic restart,          // Restart the count
    input wire logic [7:0] period_s,   // Period, zero disables
    output logic expire                // One-cycle expiry pulse
);
    logic [31:0] tick_cnt;
    logic [7:0] sec_cnt;
    wire tick = (tick_cnt == 32'(SEC_CYCLES - 1));
    wire off = (period_s == 8'h00);
    wire last = tick && (sec_cnt == period_s - 8'h01);

    // Prescaler, held clear while disabled or restarted
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            tick_cnt <= 32'h0;
        else if (off || restart || tick)
            tick_cnt <= 32'h0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // Seconds count; wraps on expiry so a silent host sees it repeat
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sec_cnt <= 8'h00;
            expire <= 1'b0;
        end else begin
            expire <= !off && !restart && last;
            if (off || restart || last)
                sec_cnt <= 8'h00;
            else if (tick)
                sec_cnt <= sec_cnt + 8'h01;
        end
    end
endmodule

// ---- tb/ccr_regs_chk.sv ----
// Port assertions for the charger configuration register bank
module ccr_regs_chk (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic reg_wr, // Strobe
    input wire logic [7:0] reg_wdata, // Data in
    input wire logic [7:0] reg_rdata, // Data out
    input wire logic reg_reset_req, // Reg reset
    input wire logic watchdog_restart_wr, // Restart write
    input wire logic watchdog_restart, // Restart bit
    input wire logic watchdog_expired, // Expiry
    input wire logic pulse_up_wr, // Up write
    input wire logic pulse_done, // Done
    input wire logic pulse_ctrl_enable, // Enable
    input wire logic pulse_volt_up_req, // Up request
    input wire logic [11:0] fast_charge_current, // mA
    input wire logic fast_charge_off, // Off
    input wire logic [12:0] charge_voltage // mV
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Write to 04h, then a quiet cycle on the same address
    sequence s_wr04;
        reg_wr && reg_addr == 8'h04 && !reg_reset_req ##1
        !reg_wr && !reg_reset_req && reg_addr == 8'h04;
    endsequence
    AST_RDATA_WRITE: assert property (s_wr04 |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("read data differs from write");
    AST_FC_DECODE: assert property (s_wr04 |=>
        fast_charge_current == ($past(reg_wdata[6], 2) ? 12'hFC0
        : {$past(reg_wdata[5:0], 2), 6'h00}))
        else $error("fast current decode wrong");
    AST_FC_OFF: assert property (s_wr04 |=>
        fast_charge_off == ($past(reg_wdata[6:0], 2) == 7'h00))
        else $error("charge off flag wrong");
    AST_RESTART: assert property (watchdog_restart_wr ##1
        !watchdog_restart_wr |-> watchdog_restart ##1 !watchdog_restart)
        else $error("restart bit not a single cycle");
    AST_PULSE_REFUSED: assert property (pulse_up_wr &&
        !pulse_ctrl_enable && !reg_wr && !$past(reg_wr) &&
        !pulse_volt_up_req |=> !pulse_volt_up_req)
        else $error("request set while disabled");
    AST_PULSE_SET: assert property (pulse_up_wr &&
        pulse_ctrl_enable && !reg_wr && !$past(reg_wr) &&
        !reg_reset_req |=> pulse_volt_up_req)
        else $error("request not set");
    AST_PULSE_DONE: assert property (pulse_volt_up_req &&
        pulse_done && !pulse_up_wr |=> !pulse_volt_up_req)
        else $error("request not cleared");
    AST_REG_RESET: assert property (reg_reset_req ##1
        !reg_wr && !reg_reset_req |=> fast_charge_current == 12'h800
        && charge_voltage == 13'h1070)
        else $error("defaults not restored");
    AST_EXPIRE: assert property (watchdog_expired |=>
        fast_charge_current == 12'h800 && !fast_charge_off)
        else $error("expiry did not restore");
endmodule
bind ccr_regs ccr_regs_chk u_ccr_regs_chk (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_reset_req(reg_reset_req),
    .watchdog_restart_wr(watchdog_restart_wr),
    .watchdog_restart(watchdog_restart),
    .watchdog_expired(watchdog_expired), .pulse_up_wr(pulse_up_wr),
    .pulse_done(pulse_done), .pulse_ctrl_enable(pulse_ctrl_enable),
    .pulse_volt_up_req(pulse_volt_up_req),
    .fast_charge_current(fast_charge_current),
    .fast_charge_off(fast_charge_off), .charge_voltage(charge_voltage));

// ---- tb/ccr_host_model.sv ----
// Host side of the register bus: single-byte writes and reads
module ccr_host_model (
    input wire logic clock, // Clock
    output logic [7:0] reg_addr, // Address
    output logic reg_wr, // Strobe
    output logic [7:0] reg_wdata, // Data out
    input wire logic [7:0] reg_rdata // Data in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // One-cycle strobe, address held so a read can follow
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #2;
        reg_wr = 1'b0;
        reg_wdata = ~d; // Released data must not look valid
    endtask
    // Read data is registered, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #2;
        reg_addr = a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask
endmodule

// ---- tb/ccr_regs_tb_top.sv ----
// Self-checking bench for the charger configuration register bank
module ccr_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, wdp;
    logic reg_wr, rreq = 1'b0, rs_wr = 1'b0, rs, exp_d;
    logic up_wr = 1'b0, dn_wr = 1'b0, done = 1'b0, pen, upr, dnr;
    logic [11:0] fcc, exit_mv, cool;
    logic [10:0] pre, term;
    logic [12:0] cv;
    logic [4:0] hrs;
    logic off, rech, t_en, stat, tmr;
    int err_count = 0;
    int checks_done = 0;
    always #12.5 clock = ~clock;
    // Short second keeps the watchdog within a brief run
    ccr_regs #(.SEC_CYCLES(4)) u_ccr_regs (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_reset_req(rreq),
        .watchdog_restart_wr(rs_wr), .watchdog_restart(rs),
        .watchdog_expired(exp_d), .pulse_up_wr(up_wr),
        .pulse_down_wr(dn_wr), .pulse_done(done),
        .pulse_ctrl_enable(pen), .pulse_volt_up_req(upr),
        .pulse_volt_down_req(dnr), .fast_charge_current(fcc),
        .fast_charge_off(off), .precharge_current(pre),
        .termination_current(term), .charge_voltage(cv),
        .precharge_exit_threshold(exit_mv), .recharge_threshold(rech),
        .termination_enable(t_en), .status_pin_disable(stat),
        .watchdog_period(wdp), .safety_timer_enable(tmr),
        .safety_timer_duration(hrs), .cool_band_current(cool));
    ccr_host_model u_host (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Write, then let the decoded outputs land
    task automatic wrs(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic pulse(ref logic s);
        @(posedge clock);
        #2;
        s = 1'b1;
        @(posedge clock);
        #2;
        s = 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic check_defaults;
        logic [7:0] e [4] = '{8'h20, 8'h13, 8'h5E, 8'h9D};
        for (int i = 0; i < 4; i++) begin
            u_host.rd(8'h04 + 8'(i), rd_val);
            chk("reg default", rd_val, e[i]);
        end
    endtask
    task automatic t_defaults;
        check_defaults();
        chk("fast mA", fcc, 16'h0800);
        chk("term mA", term, 16'h0100);
        chk("pre mA", pre, 16'h0080);
        chk("volt mV", cv, 16'h1070);
        chk("exit mV", exit_mv, 16'h0BB8);
        chk("wd s", wdp, 16'h0028);
        chk("hours", hrs, 16'h000C);
        chk("timer en", tmr, 16'h0001);
        chk("cool mA", cool, 16'h0199);
        chk("status_pin_disable", stat, 16'h0000);
        chk("pulse en", pen, 16'h0000);
        chk("term en", t_en, 16'h0001);
        chk("recharge", rech, 16'h0000);
        wrs(8'h07, 8'h8D); // Watchdog off for the field tests
    endtask
    task automatic t_fast;
        logic [7:0] c [6] = '{8'h00, 8'h01, 8'h20, 8'h3F, 8'h40, 8'h7F};
        logic [11:0] e;
        foreach (c[i]) begin
            wrs(8'h04, c[i]);
            e = c[i][6] ? 12'hFC0 : {c[i][5:0], 6'h00};
            chk("fast mA", fcc, e);
            chk("fast off", off, c[i][6:0] == 7'h00);
            chk("pre mA", pre, c[i][5:0] == 0 ? 12'h0 : 12'h80);
            chk("cool mA", cool, e / 5);
        end
        wrs(8'h05, 8'hF0);
        chk("pre mA", pre, 16'h0400);
        chk("term mA", term, 16'h0040);
    endtask
    task automatic t_volt;
        logic [5:0] c [5] = '{6'h00, 6'h17, 6'h30, 6'h31, 6'h3F};
        logic [5:0] v;
        foreach (c[i]) begin
            wrs(8'h06, {c[i], 2'b01});
            v = c[i] > 6'h30 ? 6'h30 : c[i];
            chk("volt mV", cv, 16'h0F00 + {v, 4'h0});
            chk("exit mV", exit_mv, 16'h0AF0);
        end
    endtask
    task automatic t_timer;
        logic [7:0] w [4] = '{8'h00, 8'h28, 8'h50, 8'hA0};
        logic [4:0] h [4] = '{5'h05, 5'h08, 5'h0C, 5'h14};
        for (int i = 0; i < 4; i++) begin
            wrs(8'h07, {2'b01, 2'(i), 1'b0, 2'(i), 1'b0});
            chk("wd s", wdp, w[i]);
            chk("hours", hrs, h[i]);
        end
        chk("status_pin_disable", stat, 16'h0001);
        chk("timer en", tmr, 16'h0000);
        chk("cool mA", cool, 16'h07E0);
        wrs(8'h07, 8'h8D);
    endtask
    task automatic t_pulse;
        wrs(8'h04, 8'h20);
        pulse(up_wr);
        chk("up req", upr, 16'h0000);
        wrs(8'h04, 8'hA0);
        chk("pulse en", pen, 16'h0001);
        pulse(up_wr);
        pulse(dn_wr);
        chk("up req", upr, 16'h0001);
        chk("down req", dnr, 16'h0001);
        pulse(done);
        chk("down req", dnr, 16'h0000);
        pulse(up_wr);
        wrs(8'h04, 8'h20); // Dropping the enable cancels requests
        chk("up req", upr, 16'h0000);
    endtask
    task automatic t_reset;
        wrs(8'h06, 8'hFF);
        pulse(rreq);
        u_host.wr(8'h08, 8'h55); // Unmapped: ignored, reads zero
        u_host.rd(8'h08, rd_val);
        chk("unmapped", rd_val, 16'h0000);
        check_defaults();
    endtask
    task automatic t_wdog;
        int n;
        wrs(8'h04, 8'h3F);
        wrs(8'h07, 8'h9D); // 40 s is 160 cycles here
        repeat (100) @(posedge clock);
        @(posedge clock);
        #2;
        rs_wr = 1'b1;
        @(posedge clock);
        #1;
        chk("restart bit", rs, 16'h0001);
        #1;
        rs_wr = 1'b0;
        @(posedge clock);
        #1;
        chk("restart bit", rs, 16'h0000);
        repeat (100) @(posedge clock);
        #1;
        chk("fast mA", fcc, 16'h0FC0);
        n = 0;
        while (exp_d !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("expired", exp_d, 16'h0001);
        check_defaults();
        wrs(8'h07, 8'h8D);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        #2;
        rst = 1'b0;
        t_defaults();
        t_fast();
        t_volt();
        t_timer();
        t_pulse();
        t_reset();
        t_wdog();
        tally_and_finish();
    end
    // Tests need about 400 cycles; allow fifty times that
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end
endmodule
